// [dv/hbdh_channel_chk.sv]
`timescale 1ns/1ns
module hbdh_channel_chk #(
   parameter int POLL_CYC = 4
) (
   input wire logic                     clk,
   input wire logic                     rst_n,
   input wire logic                     is_tx,
   input wire logic                     enable,
   input wire logic                     status_writeback_inhibit,
   input wire logic [31:0]              message_pointer_addr,
   input wire hbdh_pkg::hbdh_mem_req_s  mem_req,
   input wire hbdh_pkg::hbdh_mem_rsp_s  mem_rsp,
   input wire hbdh_pkg::hbdh_rx_end_s   rx_end,
   input wire hbdh_pkg::hbdh_octet_s    tx_out,
   input wire logic                     tx_out_valid,
   input wire logic                     tx_out_ready,
   input wire logic                     rx_in_ready,
   input wire logic                     buffer_end_irq,
   input wire logic                     message_end_irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence rx_msg_end;
      rx_end.end_of_message_flag && !is_tx && enable && !status_writeback_inhibit;
   endsequence
   sequence mem_write;
      mem_req.req && mem_req.wr;
   endsequence
   req_hold_a: assert property (
      (mem_req.req && !mem_rsp.done && enable) ##1 enable |-> mem_req.req && $stable(mem_req))
      else $error("memory request changed before done");
   eob_pulse_a: assert property (buffer_end_irq |=> !buffer_end_irq)
      else $error("buffer end irq longer than one cycle");
   eom_pulse_a: assert property (message_end_irq |=> !message_end_irq)
      else $error("message end irq longer than one cycle");
   tx_hold_a: assert property (
      (tx_out_valid && !tx_out_ready && enable) ##1 enable |-> tx_out_valid && $stable(tx_out))
      else $error("stalled tx octet changed");
   msgptr_align_a: assert property (
      mem_req.req && mem_req.wr && mem_req.addr == message_pointer_addr |-> mem_req.wdata[1:0] == 2'b00)
      else $error("message pointer not dword aligned");
   tx_dir_a: assert property (tx_out_valid |-> is_tx)
      else $error("tx octet offered by a receive channel");
   rx_dir_a: assert property (rx_in_ready |-> !is_tx)
      else $error("rx ready raised by a transmit channel");
   status_write_a: assert property (rx_msg_end |-> ##[1:200] mem_write)
      else $error("no status write after end of message");
   disable_drop_a: assert property (!enable [*2] |-> !mem_req.req && !tx_out_valid)
      else $error("requests kept while disabled");
endmodule
bind hbdh_channel hbdh_channel_chk #(.POLL_CYC(POLL_CYC)) u_chk (.clk, .rst_n, .is_tx, .enable,
   .status_writeback_inhibit, .message_pointer_addr, .mem_req, .mem_rsp, .rx_end, .tx_out,
   .tx_out_valid, .tx_out_ready, .rx_in_ready, .buffer_end_irq, .message_end_irq);

// [dv/hbdh_channel_test.sv]
`timescale 1ns/1ns
module hbdh_channel_test;
   import hbdh_pkg::*;
   localparam logic [31:0] MSGP = 32'h0000_0080;
   logic          clk, rst_n, is_tx, enable, act, inhibit, tx_rdy, rx_v, tx_v, rx_rdy;
   logic          eob_irq, eom_irq, transp, idle_o, deact_o;
   logic [3:0]    lat;
   logic [31:0]   head, watch;
   hbdh_octet_s   rx_in, tx_out;
   hbdh_rx_end_s  rx_end;
   hbdh_mem_req_s mem_req;
   hbdh_mem_rsp_s mem_rsp;
   int            err_count = 0, checks = 0, n_eob = 0, n_eom = 0, n_rd = 0, cyc = 0;
   int            nff, nzero, nmsg, e0, m0, r0;
   logic [7:0]    txq [$];
   logic [6:0]    flg [8] = '{7'h00, 7'h40, 7'h20, 7'h10, 7'h08, 7'h0C, 7'h02, 7'h01};
   logic [3:0]    code [8] = '{4'h0, 4'h1, 4'h2, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC};
   hbdh_channel #(.POLL_CYC(4)) dut (.clk, .rst_n, .is_tx, .enable, .channel_activate(act),
      .transparent_mode(transp), .status_writeback_inhibit(inhibit), .head_pointer(head),
      .message_pointer_addr(MSGP), .mem_req, .mem_rsp, .rx_in, .rx_in_valid(rx_v),
      .rx_in_ready(rx_rdy), .rx_end, .tx_out, .tx_out_valid(tx_v), .tx_out_ready(tx_rdy),
      .buffer_end_irq(eob_irq), .message_end_irq(eom_irq), .channel_idle(idle_o),
      .channel_deactivated(deact_o));
   hbdh_mem_model u_mem (.clk, .rst_n, .lat, .mem_req, .mem_rsp);
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (tx_v && tx_rdy) txq.push_back(tx_out.octet);
      if (eob_irq) n_eob <= n_eob + 1;
      if (eom_irq) n_eom <= n_eom + 1;
      if (mem_req.req && mem_rsp.done && !mem_req.wr && mem_req.addr == watch) n_rd <= n_rd + 1;
   end
   // the octet receiver stalls every third cycle so the two-entry buffer fills
   always @(negedge clk) tx_rdy <= (cyc % 3) != 0;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic desc(input logic [31:0] a, input logic [31:0] bd, input logic [31:0] dp,
                       input logic [31:0] nx);
      u_mem.mem[a[31:2]] = bd;
      u_mem.mem[a[31:2] + 30'h1] = dp;
      u_mem.mem[a[31:2] + 30'h2] = nx;
   endtask
   task automatic start(input logic tx, input logic [31:0] h);
      repeat (2) @(negedge clk) enable = 0;
      @(negedge clk) begin is_tx = tx; head = h; enable = 1; end
      @(negedge clk) act = 1;
      @(negedge clk) act = 0;
   endtask
   task automatic wait_own(input logic [31:0] a, input logic v);
      for (int i = 0; i < 3000 && u_mem.mem[a[31:2]][31] !== v; i++) @(posedge clk);
   endtask
   task automatic send(input logic [7:0] o, input logic l);
      @(negedge clk) begin rx_in = '{octet: o, last: l}; rx_v = 1; end
      for (int k = 0; k < 500 && rx_rdy !== 1'b1; k++) @(negedge clk);
      @(negedge clk) rx_v = 0;
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      $display("ERROR %0t: watchdog expired", $time);
      end_of_test();
   end
   initial begin
      {rst_n, is_tx, enable, act, inhibit, rx_v, transp} = '0;
      {head, rx_in, rx_end, lat, watch} = '0;
      repeat (4) @(negedge clk);
      rst_n = 1;
      // tx: idle codes 0..2 with pad count 2, three octets from an odd byte address
      u_mem.mem[30'h400] = 32'h3322_1155;
      u_mem.mem[30'h401] = 32'h0000_0044;
      u_mem.mem[MSGP[31:2]] = 32'h0;
      for (int i = 0; i < 3; i++)
         desc(32'h100 + 16 * i, {4'hA, 1'b0, 2'(i), 1'b1, 8'h02, 16'h0003}, 32'h1001,
              32'h110 + 16 * i);
      desc(32'h130, 32'h0, 32'h1001, 32'h100);
      watch = 32'h130;
      start(1'b1, 32'h100);
      wait_own(32'h120, 1'b0);
      for (int i = 0; i < 300 && u_mem.mem[MSGP[31:2]] !== 32'h130; i++) @(posedge clk);
      r0 = n_rd;
      repeat (100) @(posedge clk);
      chk(32'(n_rd > r0 + 1), 1);
      for (int i = 0; i < 3; i++) chk(u_mem.mem[30'h40 + 30'(4 * i)], 32'h2000_0003);
      chk(u_mem.mem[MSGP[31:2]], 32'h130);
      {nff, nzero, nmsg} = '0;
      foreach (txq[j]) begin
         if (txq[j] == 8'hFF) nff++;
         if (txq[j] == 8'h00) nzero++;
         if (j + 3 < txq.size() && txq[j] == 8'h11 && txq[j+1] == 8'h22 && txq[j+2] == 8'h33)
         begin
            nmsg++;
            chk(32'(txq[j+3] === 8'h44), 0);
         end
      end
      chk(nmsg, 3);
      chk(32'(nff >= 2), 1);
      chk(32'(nzero >= 2), 1);
      $display("test tx done");
      // rx: eight two-octet buffers, one per end condition, slow memory
      lat = 4'h3;
      for (int i = 0; i < 8; i++) begin
         desc(32'h300 + 16 * i, {3'b000, 1'(i), 14'h0, 14'h0002}, 32'h1401 + 16 * i,
              32'h310 + 16 * i);
         u_mem.mem[30'h500 + 30'(4 * i)] = 32'h0;
      end
      desc(32'h380, 32'hC000_0000, 32'h1500, 32'h300);
      e0 = n_eob;
      m0 = n_eom;
      start(1'b0, 32'h300);
      for (int i = 0; i < 8; i++) begin
         send(8'h60 + 8'(i), 1'b0);
         send(8'hA0 + 8'(i), 1'b1);
         @(negedge clk) rx_end = {1'b1, flg[i]};
         @(negedge clk) rx_end = '0;
         wait_own(32'h300 + 16 * i, 1'b1);
         chk(u_mem.mem[30'hC0 + 30'(4 * i)], {3'b101, 9'h0, code[i], 16'h0002});
         chk(u_mem.mem[30'h500 + 30'(4 * i)], {8'h00, 8'hA0 + 8'(i), 8'h60 + 8'(i), 8'h00});
      end
      watch = 32'h380;
      repeat (60) @(posedge clk);
      r0 = n_rd;
      repeat (100) @(posedge clk);
      chk(n_rd, r0);
      chk(n_eob - e0, 4);
      chk(n_eom - m0, 8);
      @(negedge clk) chk(idle_o, 1);
      $display("test rx done");
      // rx, transparent: a host-owned buffer deactivates the channel
      transp = 1;
      start(1'b0, 32'h380);
      repeat (30) @(posedge clk);
      @(negedge clk) chk(deact_o, 1);
      chk(idle_o, 1);
      $display("test transparent done");
      // tx, status writeback inhibited, pad fill off: one shared flag only
      inhibit = 1;
      desc(32'h200, 32'hA000_0003, 32'h1001, 32'h210);
      desc(32'h210, 32'h0, 32'h1001, 32'h200);
      txq.delete();
      start(1'b1, 32'h200);
      for (int i = 0; i < 300 && u_mem.mem[MSGP[31:2]] !== 32'h210; i++) @(posedge clk);
      repeat (20) @(posedge clk);
      chk(u_mem.mem[30'h80], 32'hA000_0003);
      chk(u_mem.mem[MSGP[31:2]], 32'h210);
      chk(txq.size(), 4);
      chk(txq[3], 8'h7E);
      $display("test inhibit done");
      // tx, repeat: the message goes out again and the descriptor is left alone
      inhibit = 0;
      desc(32'h240, 32'hA000_8003, 32'h1001, 32'h240);
      txq.delete();
      nmsg = 0;
      start(1'b1, 32'h240);
      repeat (150) @(posedge clk);
      foreach (txq[j]) if (txq[j] == 8'h33) nmsg++;
      chk(32'(nmsg >= 2), 1);
      chk(u_mem.mem[30'h90], 32'hA000_8003);
      $display("test repeat done");
      end_of_test();
   end
endmodule

// [dv/hbdh_mem_model.sv]
`timescale 1ns/1ns
module hbdh_mem_model (
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire logic [3:0]              lat,
   input  wire hbdh_pkg::hbdh_mem_req_s mem_req,
   output hbdh_pkg::hbdh_mem_rsp_s      mem_rsp
);
   import hbdh_pkg::*;
   // word store; from 1000h up the data buffers are written one byte at a time
   logic [31:0] mem [logic [29:0]];
   logic [3:0]  wait_reg;
   logic [31:0] w;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_reg <= 4'h0;
         mem_rsp  <= '0;
      end else begin
         mem_rsp.done  <= 1'b0;
         // read data is not held after the answer, so a late sample is caught
         mem_rsp.rdata <= ~mem_rsp.rdata;
         // a request withdrawn by the channel forgets its wait states
         if (!mem_req.req) wait_reg <= 4'h0;
         if (mem_req.req && !mem_rsp.done) begin
            if (wait_reg < lat) begin
               wait_reg <= wait_reg + 4'h1;
            end else begin
               wait_reg     <= 4'h0;
               mem_rsp.done <= 1'b1;
               w = mem.exists(mem_req.addr[31:2]) ? mem[mem_req.addr[31:2]] : 32'h0;
               if (!mem_req.wr) begin
                  mem_rsp.rdata <= w;
               end else if (mem_req.addr >= 32'h0000_1000) begin
                  w[8*mem_req.addr[1:0] +: 8] = mem_req.wdata[7:0];
                  mem[mem_req.addr[31:2]] = w;
               end else begin
                  mem[mem_req.addr[31:2]] = mem_req.wdata;
               end
            end
         end
      end
   end
endmodule

// [hw/hbdh_channel.sv]
`timescale 1ns/1ns
`include "hbdh_regs.svh"
// Operation
// - idle code select 1 sends FFh, 2 sends 00h; 3 is reserved
// - idle code select 0 sends flag 7Eh as idle fill
// - pad fill off: one shared flag closes and opens messages
// - pad fill on: at least pad count idle codes between flags
// - repeat bit 15 set with end-of-message bit 29 set: transmit the message again
// - transmit buffer length field is octet count to send
// - transmit owner 1 is device; poll host-owned descriptor when enabled
// - receive owner 0 is device; poll until host writes 0
// - no_poll set and host-owned: wait for channel activate request
// - end-of-buffer interrupt only when its enable bit is set
// - receive buffer length is capacity; host keeps it at most 8 k
// - status word overwrites first descriptor word when configured
// - transmit ownership sense is inverse of receive sense
// - transmit status owner 0, end-of-message copied to bit 29
// - transmit status length is octets actually sent
// - receive status owner 1 when buffer processing finishes
// - receive end-of-message set on closing flag or error end
// - error codes 0 none, 1 overflow, 2 alignment change, 8 out-of-frame
// - code 9 check mismatch, code 10 octet misalign, 10 wins
// - code 11 reported on abort termination
// - long message: code 12, stop transfer, resume flag search
// - next pointer bits 31:2 with 00b form the address
// - data pointer is an unaligned byte address
// - writeback on: status, next pointer, next descriptor, message pointer
// - writeback inhibited: message pointer is next, then store its next
// - descriptor is three dwords at 00h, 04h, 08h
module hbdh_channel #(
   parameter int POLL_CYC = `HBDH_POLL_CYC
) (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  is_tx,
   input  wire logic                  enable,
   input  wire logic                  channel_activate,
   input  wire logic                  transparent_mode,
   input  wire logic                  status_writeback_inhibit,
   input  wire logic [31:0]           head_pointer,
   input  wire logic [31:0]           message_pointer_addr,
   output hbdh_pkg::hbdh_mem_req_s    mem_req,
   input  wire hbdh_pkg::hbdh_mem_rsp_s mem_rsp,
   input  wire hbdh_pkg::hbdh_octet_s rx_in,
   input  wire logic                  rx_in_valid,
   output logic                       rx_in_ready,
   input  wire hbdh_pkg::hbdh_rx_end_s rx_end,
   output hbdh_pkg::hbdh_octet_s      tx_out,
   output logic                       tx_out_valid,
   input  wire logic                  tx_out_ready,
   output logic                       buffer_end_irq,
   output logic                       message_end_irq,
   output logic                       channel_idle,
   output logic                       channel_deactivated
);
   import hbdh_pkg::*;

   typedef struct packed {
      hbdh_state_e   st;
      hbdh_mem_req_s req;
      logic [31:0]   cur;
      logic [31:0]   bd;
      logic [31:0]   dptr;
      logic [31:0]   nxt;
      logic [13:0]   cnt;
      logic [7:0]    gap;
      logic          gap_flag;
      logic [31:0]   poll;
      logic          ended;
      logic [3:0]    err;
      hbdh_octet_s   b0;
      hbdh_octet_s   b1;
      logic [1:0]    fill;
      logic          rdy;
      logic          eob_irq;
      logic          eom_irq;
      logic          idle;
      logic          deact;
      logic          vld;
   } hbdh_st_s;

   hbdh_st_s s_reg;
   hbdh_st_s s_next;

   logic host_owned;
   logic [7:0] idle_octet;
   logic [3:0] err_code;
   logic emit;
   hbdh_octet_s emit_word;

   always_comb begin
      host_owned = is_tx ? ~s_reg.bd[`HBDH_OWNER_BIT]
                         : s_reg.bd[`HBDH_OWNER_BIT];
      case (s_reg.bd[`HBDH_IC_HI:`HBDH_IC_LO])
         2'h1:    idle_octet = `HBDH_ONES_OCTET;
         2'h2:    idle_octet = `HBDH_ZERO_OCTET;
         default: idle_octet = `HBDH_FLAG_OCTET;
      endcase
      // fixed priority among simultaneous terminations
      if (rx_end.long_message_error)          err_code = `HBDH_ERR_LONG;
      else if (rx_end.abort_termination)      err_code = `HBDH_ERR_ABORT;
      else if (rx_end.octet_misalign)         err_code = `HBDH_ERR_OCTET;
      else if (rx_end.crc_bad)                err_code = `HBDH_ERR_CHECK;
      else if (rx_end.out_of_frame_error)     err_code = `HBDH_ERR_OOF;
      else if (rx_end.frame_alignment_change) err_code = `HBDH_ERR_ALIGNCHG;
      else if (rx_end.overflow_error)         err_code = `HBDH_ERR_OVFL;
      else                                    err_code = `HBDH_ERR_NONE;
   end

   always_comb begin
      s_next = s_reg;
      s_next.eob_irq = 1'b0;
      s_next.eom_irq = 1'b0;
      emit = 1'b0;
      emit_word = '0;
      // two-entry output buffer drains toward the serial side
      if (s_reg.fill != 2'h0 && tx_out_ready) begin
         s_next.b0 = s_reg.b1;
         s_next.fill = s_reg.fill - 2'h1;
      end
      if (s_reg.req.req && mem_rsp.done) begin
         s_next.req.req = 1'b0;
      end
      case (s_reg.st)
         HBDH_IDLE: begin
            s_next.idle = 1'b1;
            if (enable && channel_activate) begin
               s_next.cur = {head_pointer[31:2], 2'b00};
               s_next.deact = 1'b0;
               s_next.req = '{1'b1, 1'b0, {head_pointer[31:2], 2'b00} + `HBDH_OFS_BD, 32'h0};
               s_next.st = HBDH_RD_BD;
               s_next.idle = 1'b0;
            end
         end
         HBDH_RD_BD: begin
            if (s_reg.req.req && mem_rsp.done) begin
               s_next.bd = mem_rsp.rdata;
               s_next.st = HBDH_RD_DATA;
               s_next.req = '{1'b1, 1'b0, s_reg.cur + `HBDH_OFS_DATA, 32'h0};
               if (is_tx ? ~mem_rsp.rdata[`HBDH_OWNER_BIT] : mem_rsp.rdata[`HBDH_OWNER_BIT]) begin
                  s_next.req.req = 1'b0;
                  s_next.idle = 1'b1;
                  if (!is_tx && transparent_mode) begin
                     s_next.deact = 1'b1;
                     s_next.st = HBDH_IDLE;
                  end else if (mem_rsp.rdata[`HBDH_NP_BIT]) begin
                     s_next.st = HBDH_HALT;
                  end else begin
                     s_next.poll = 32'h0;
                     s_next.st = HBDH_POLL_WAIT;
                  end
               end
            end
         end
         HBDH_POLL_WAIT: begin
            // a message pointer write may still be in flight; it must land first
            if (!s_reg.req.req) begin
               s_next.poll = s_reg.poll + 32'h1;
               if (s_reg.poll >= 32'(POLL_CYC - 1)) begin
                  s_next.idle = 1'b0;
                  s_next.req = '{1'b1, 1'b0, s_reg.cur + `HBDH_OFS_BD, 32'h0};
                  s_next.st = HBDH_RD_BD;
               end
            end
         end
         HBDH_HALT: begin
            if (channel_activate) begin
               s_next.idle = 1'b0;
               s_next.req = '{1'b1, 1'b0, s_reg.cur + `HBDH_OFS_BD, 32'h0};
               s_next.st = HBDH_RD_BD;
            end
         end
         HBDH_RD_DATA: begin
            if (s_reg.req.req && mem_rsp.done) begin
               s_next.dptr = mem_rsp.rdata;
               s_next.req = '{1'b1, 1'b0, s_reg.cur + `HBDH_OFS_NEXT, 32'h0};
               s_next.st = HBDH_RD_NEXT;
            end
         end
         HBDH_RD_NEXT: begin
            if (s_reg.req.req && mem_rsp.done) begin
               s_next.nxt = {mem_rsp.rdata[31:2], 2'b00};
               s_next.cnt = 14'h0;
               s_next.ended = 1'b0;
               s_next.err = `HBDH_ERR_NONE;
               s_next.st = HBDH_XFER;
               if (is_tx) begin
                  s_next.req = '{1'b1, 1'b0, s_reg.dptr, 32'h0};
               end
            end
         end
         HBDH_XFER: begin
            if (is_tx) begin
               // byte fetch from unaligned address, lane picked by low bits
               if (s_reg.cnt == s_reg.bd[`HBDH_LEN_HI:`HBDH_LEN_LO]) begin
                  s_next.req.req = 1'b0;
                  s_next.ended = s_reg.bd[`HBDH_EOM_BIT];
                  s_next.gap = 8'h0;
                  s_next.gap_flag = 1'b0;
                  s_next.st = s_reg.bd[`HBDH_EOM_BIT] ? HBDH_TX_GAP : HBDH_WR_STAT;
               end else if (s_reg.req.req && mem_rsp.done && s_reg.fill != 2'h2) begin
                  emit = 1'b1;
                  emit_word.octet = mem_rsp.rdata[8*s_reg.req.addr[1:0] +: 8];
                  emit_word.last = (s_reg.cnt + 14'h1 == s_reg.bd[`HBDH_LEN_HI:`HBDH_LEN_LO])
                                   && s_reg.bd[`HBDH_EOM_BIT];
                  s_next.cnt = s_reg.cnt + 14'h1;
                  s_next.req = '{1'b1, 1'b0, s_reg.dptr + {18'h0, s_reg.cnt} + 32'h1, 32'h0};
                  if (s_reg.cnt + 14'h1 == s_reg.bd[`HBDH_LEN_HI:`HBDH_LEN_LO])
                     s_next.req.req = 1'b0;
               end else if (s_reg.req.req && mem_rsp.done) begin
                  // both slots taken: drop this answer and fetch the same byte again
                  s_next.req.req = 1'b1;
               end
            end else begin
               s_next.rdy = (s_reg.cnt != s_reg.bd[`HBDH_LEN_HI:`HBDH_LEN_LO]) && !s_reg.req.req;
               if (s_reg.rdy && rx_in_valid) begin
                  s_next.rdy = 1'b0;
                  s_next.req = '{1'b1, 1'b1, s_reg.dptr + {18'h0, s_reg.cnt}, {24'h0, rx_in.octet}};
                  s_next.cnt = s_reg.cnt + 14'h1;
               end
               if (rx_end.end_of_message_flag) begin
                  s_next.rdy = 1'b0;
                  s_next.ended = 1'b1;
                  s_next.err = err_code;
                  s_next.st = HBDH_WR_STAT;
               end else if (s_reg.cnt == s_reg.bd[`HBDH_LEN_HI:`HBDH_LEN_LO] && !s_reg.req.req) begin
                  s_next.rdy = 1'b0;
                  s_next.st = HBDH_WR_STAT;
               end
            end
         end
         HBDH_TX_GAP: begin
            if (s_reg.fill != 2'h2) begin
               emit = 1'b1;
               if (!s_reg.bd[`HBDH_PAD_FILL_ENABLE_BIT] || s_reg.gap_flag) begin
                  emit_word.octet = `HBDH_FLAG_OCTET;
                  s_next.st = HBDH_WR_STAT;
               end else if (s_reg.gap == 8'h0) begin
                  emit_word.octet = `HBDH_FLAG_OCTET;
                  s_next.gap = 8'h1;
                  s_next.gap_flag = (s_reg.bd[`HBDH_PAD_COUNT_HI:`HBDH_PAD_COUNT_LO] == 8'h0);
               end else begin
                  emit_word.octet = idle_octet;
                  s_next.gap = s_reg.gap + 8'h1;
                  s_next.gap_flag = (s_reg.gap >= s_reg.bd[`HBDH_PAD_COUNT_HI:`HBDH_PAD_COUNT_LO]);
               end
            end
         end
         HBDH_WR_STAT: begin
            if (!s_reg.req.req) begin
               s_next.eob_irq = s_reg.bd[`HBDH_BUFFER_END_IRQ_ENABLE_BIT];
               s_next.eom_irq = s_reg.ended;
               if (is_tx && s_reg.bd[`HBDH_REPEAT_BIT] && s_reg.bd[`HBDH_EOM_BIT]) begin
                  s_next.cnt = 14'h0;
                  s_next.req = '{1'b1, 1'b0, s_reg.dptr, 32'h0};
                  s_next.st = HBDH_XFER;
               end else if (!status_writeback_inhibit) begin
                  s_next.req = '{1'b1, 1'b1, s_reg.cur + `HBDH_OFS_BD,
                     is_tx ? {2'b00, s_reg.ended, 15'h0, s_reg.cnt}
                           : {2'b10, s_reg.ended, 9'h0, s_reg.err, 2'b00, s_reg.cnt}};
                  s_next.st = HBDH_RD_NEXT_BD;
               end else begin
                  s_next.req = '{1'b1, 1'b0, s_reg.nxt + `HBDH_OFS_BD, 32'h0};
                  s_next.cur = s_reg.nxt;
                  s_next.st = HBDH_WR_MSG;
               end
            end
         end
         HBDH_RD_NEXT_BD: begin
            if (!s_reg.req.req) begin
               s_next.cur = s_reg.nxt;
               s_next.req = '{1'b1, 1'b0, s_reg.nxt + `HBDH_OFS_BD, 32'h0};
               s_next.st = HBDH_WR_MSG;
            end
         end
         HBDH_WR_MSG: begin
            if (s_reg.req.req && mem_rsp.done) begin
               s_next.bd = mem_rsp.rdata;
               s_next.req = '{1'b1, 1'b1, message_pointer_addr, s_reg.cur};
               s_next.st = HBDH_POLL_WAIT;
               s_next.poll = 32'(POLL_CYC);
            end
         end
         default: s_next.st = HBDH_IDLE;
      endcase
      if (emit) begin
         if (s_next.fill == 2'h0 || (s_next.fill == 2'h1 && s_reg.fill == 2'h2)) begin
            if (s_next.fill == 2'h0) s_next.b0 = emit_word;
            else s_next.b1 = emit_word;
         end else begin
            s_next.b1 = emit_word;
         end
         s_next.fill = s_next.fill + 2'h1;
      end
      if (!enable) begin
         s_next.st = HBDH_IDLE;
         s_next.req.req = 1'b0;
         s_next.rdy = 1'b0;
         s_next.fill = 2'h0;
      end
      s_next.vld = (s_next.fill != 2'h0);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '{st: HBDH_IDLE, default: '0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign mem_req         = s_reg.req;
   assign rx_in_ready     = s_reg.rdy;
   assign tx_out          = s_reg.b0;
   assign tx_out_valid    = s_reg.vld;
   assign buffer_end_irq  = s_reg.eob_irq;
   assign message_end_irq = s_reg.eom_irq;
   assign channel_idle    = s_reg.idle;
   assign channel_deactivated = s_reg.deact;
endmodule

// [hw/hbdh_pkg.sv]
package hbdh_pkg;
   typedef struct packed {
      logic        req;
      logic        wr;
      logic [31:0] addr;
      logic [31:0] wdata;
   } hbdh_mem_req_s;

   typedef struct packed {
      logic        done;
      logic [31:0] rdata;
   } hbdh_mem_rsp_s;

   typedef struct packed {
      logic [7:0] octet;
      logic       last;
   } hbdh_octet_s;

   typedef struct packed {
      logic       end_of_message_flag;
      logic       overflow_error;
      logic       frame_alignment_change;
      logic       out_of_frame_error;
      logic       crc_bad;
      logic       octet_misalign;
      logic       abort_termination;
      logic       long_message_error;
   } hbdh_rx_end_s;

   typedef enum logic [3:0] {
      HBDH_IDLE, HBDH_RD_BD, HBDH_POLL_WAIT, HBDH_RD_DATA, HBDH_RD_NEXT,
      HBDH_XFER, HBDH_TX_GAP, HBDH_WR_STAT, HBDH_RD_NEXT_BD, HBDH_WR_MSG, HBDH_HALT
   } hbdh_state_e;
endpackage

// [hw/hbdh_regs.svh]
`ifndef HBDH_REGS_SVH
`define HBDH_REGS_SVH
// descriptor layout, byte offsets within a message descriptor
`define HBDH_OFS_BD        32'h0000_0000
`define HBDH_OFS_DATA      32'h0000_0004
`define HBDH_OFS_NEXT      32'h0000_0008
// buffer descriptor bit positions
`define HBDH_OWNER_BIT     31
`define HBDH_NP_BIT        30
`define HBDH_EOM_BIT       29
`define HBDH_BUFFER_END_IRQ_ENABLE_BIT      28
`define HBDH_IC_HI         26
`define HBDH_IC_LO         25
`define HBDH_PAD_FILL_ENABLE_BIT     24
`define HBDH_PAD_COUNT_HI     23
`define HBDH_PAD_COUNT_LO     16
`define HBDH_REPEAT_BIT    15
`define HBDH_ERR_HI        19
`define HBDH_ERR_LO        16
`define HBDH_LEN_HI        13
`define HBDH_LEN_LO        0
// idle fill octets
`define HBDH_FLAG_OCTET    8'h7E
`define HBDH_ONES_OCTET    8'hFF
`define HBDH_ZERO_OCTET    8'h00
// receive error codes
`define HBDH_ERR_NONE      4'h0
`define HBDH_ERR_OVFL      4'h1
`define HBDH_ERR_ALIGNCHG  4'h2
`define HBDH_ERR_OOF       4'h8
`define HBDH_ERR_CHECK     4'h9
`define HBDH_ERR_OCTET     4'hA
`define HBDH_ERR_ABORT     4'hB
`define HBDH_ERR_LONG      4'hC
// polling interval
`define HBDH_POLL_NS       1000
`define HBDH_CLK_NS        10
`define HBDH_POLL_CYC      (`HBDH_POLL_NS / `HBDH_CLK_NS)
`endif
